//--- obcd_option_decode.sv
// Purpose: hold and decode the two static option bytes into settings
// Assumes: core_clk 100 MHz, CPU cycles counted on core_clk
// Notes: all settings are captured once after each reset release
`default_nettype none
module obcd_option_decode
	import obcd_pkg::*;
#(
	parameter int LONG_DELAY = OBCD_LONG_DELAY,
	parameter int SHORT_DELAY = OBCD_SHORT_DELAY,
	parameter bit MASK_VARIANT = 1'b0,
	parameter logic [7:0] MASK_BYTE0 = OBCD_SHIP_BYTE0,
	parameter logic [7:0] MASK_BYTE1 = OBCD_SHIP_BYTE1,
	parameter logic [7:0] UNBONDED_64 = 8'hf0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cold_reset,
	input wire logic programming_mode,
	input wire logic in_circuit_programming,
	input wire logic test_mode,
	input wire logic halt_exit,
	input wire logic user_erase_done,
	input wire logic [OBCD_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [OBCD_DATA_W-1:0] avs_writedata,
	output logic [OBCD_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic halt_watchdog_reset_select,
	output logic watchdog_activation_select,
	output logic clock_safety_disable,
	output logic [1:0] voltage_detect_level,
	output logic low_voltage_reset_detector,
	output logic aux_voltage_detector,
	output logic package_80pin,
	output logic package_64pin,
	output logic readout_protect_n,
	output logic user_mem_block,
	output logic user_mem_erase,
	output logic reset_delay_select,
	output logic cpu_reset_hold,
	output logic halt_exit_hold,
	output logic [1:0] clock_source_type,
	output logic clk_src_resonator,
	output logic clk_src_rc,
	output logic clk_src_external,
	output logic [2:0] oscillator_range,
	output logic range_lowest,
	output logic range_low_mid,
	output logic range_high_mid,
	output logic range_highest,
	output logic range_sets_drive,
	output logic doubler_disable,
	output logic [7:0] unbonded_pullup
);
	obcd_state_s state_reg;
	obcd_state_s state_next;
	logic prog_ok;
	logic req;
	logic [7:0] src0;
	logic [7:0] src1;

	function automatic logic [OBCD_CNT_W-1:0] delay_load(input logic sel);
		delay_load = sel ? OBCD_CNT_W'(SHORT_DELAY - 1)
			: OBCD_CNT_W'(LONG_DELAY - 1);
	endfunction

	assign prog_ok = state_reg.sync2[OBCD_SY_PROG];
	assign req = avs_read | avs_write;
	// mask parts decode from the mask bytes; the stored bytes are still read back on the bus
	assign src0 = MASK_VARIANT ? MASK_BYTE0 : state_reg.byte0;
	assign src1 = MASK_VARIANT ? MASK_BYTE1 : state_reg.byte1;

	always_comb begin
		state_next = state_reg;
		state_next.sync1 = {test_mode, in_circuit_programming,
			programming_mode};
		state_next.sync2 = state_reg.sync1;
		state_next.waitreq = 1'b1;

		// settings are latched on the first edge after release
		if (!state_reg.captured) begin
			state_next.captured = 1'b1;
			state_next.cap0 = src0;
			state_next.cap1 = src1;
			state_next.lvd_on = src0[OBCD_B0_VD_HI:OBCD_B0_VD_LO]
				!= OBCD_VD_OFF;
			state_next.avd_on = state_next.lvd_on;
			state_next.pkg80 = {src1[OBCD_B1_PKG_HI], src0[OBCD_B0_PKG_LO]}
				== OBCD_PKG_80;
			state_next.pkg64 = {src1[OBCD_B1_PKG_HI], src0[OBCD_B0_PKG_LO]}
				== OBCD_PKG_64;
			state_next.src_res = src1[OBCD_B1_SRC_HI:OBCD_B1_SRC_LO]
				== OBCD_SRC_RESONATOR;
			state_next.src_rc = src1[OBCD_B1_SRC_HI:OBCD_B1_SRC_LO]
				== OBCD_SRC_RC;
			state_next.src_ext = src1[OBCD_B1_SRC_HI:OBCD_B1_SRC_LO]
				== OBCD_SRC_EXTERNAL;
			state_next.range_hot = '0;
			case (src1[OBCD_B1_RNG_HI:OBCD_B1_RNG_LO])
				OBCD_RNG_1_2: state_next.range_hot = 4'h1;
				OBCD_RNG_2_4: state_next.range_hot = 4'h2;
				OBCD_RNG_4_8: state_next.range_hot = 4'h4;
				OBCD_RNG_8_16: state_next.range_hot = 4'h8;
				default: state_next.range_hot = 4'h0;
			endcase
			state_next.range_drive = state_next.src_res;
			state_next.pad_pullup = state_next.pkg64 ? UNBONDED_64
				: 8'h00;
			state_next.hold_cnt = delay_load(src1[OBCD_B1_DELAY]);
			state_next.reset_hold = 1'b1;
		end else if (state_reg.reset_hold || state_reg.halt_hold) begin
			if (state_reg.hold_cnt != '0) begin
				state_next.hold_cnt = state_reg.hold_cnt - 1'b1;
			end else begin
				state_next.reset_hold = 1'b0;
				state_next.halt_hold = 1'b0;
			end
		end else if (halt_exit) begin
			state_next.halt_hold = 1'b1;
			state_next.hold_cnt = delay_load(state_reg.cap1[OBCD_B1_DELAY]);
		end

		// protection uses the frozen byte so it cannot be dropped live
		state_next.user_block = state_reg.captured
			&& !state_reg.cap0[OBCD_B0_PROT]
			&& (state_reg.sync2[OBCD_SY_INCIRC]
			|| state_reg.sync2[OBCD_SY_TEST]);

		case (state_reg.fsm)
			OBCD_IDLE: begin
				state_next.user_erase = 1'b0;
			end
			OBCD_WIPE_USER: begin
				state_next.user_erase = 1'b1;
				if (user_erase_done) begin
					state_next.user_erase = 1'b0;
					state_next.fsm = OBCD_WIPE_OPT;
				end
			end
			OBCD_WIPE_OPT: begin
				state_next.byte0 = OBCD_ERASED;
				state_next.byte1 = OBCD_ERASED;
				state_next.fsm = OBCD_IDLE;
			end
			default: begin
				state_next.fsm = OBCD_IDLE;
			end
		endcase

		// one wait cycle, then a single cycle with waitrequest low
		if (req && state_reg.waitreq) begin
			state_next.waitreq = 1'b0;
			if (avs_read) begin
				state_next.rdata = '0;
				case (avs_address)
					OBCD_OFF_BYTE0:
						if (prog_ok)
							state_next.rdata[7:0] = state_reg.byte0;
					OBCD_OFF_BYTE1:
						if (prog_ok)
							state_next.rdata[7:0] = state_reg.byte1;
					OBCD_OFF_STATUS: begin
						state_next.rdata[OBCD_STAT_PROG] = prog_ok;
						state_next.rdata[OBCD_STAT_BUSY] =
							state_reg.fsm != OBCD_IDLE;
						state_next.rdata[OBCD_STAT_HOLD] =
							state_reg.reset_hold | state_reg.halt_hold;
						state_next.rdata[OBCD_STAT_BLOCK] = state_reg.user_block;
						state_next.rdata[OBCD_STAT_WIPE] = state_reg.user_erase;
					end
					OBCD_OFF_CAPTURED:
						state_next.rdata[15:0] = {state_reg.cap1, state_reg.cap0};
					default: state_next.rdata = '0;
				endcase
			end
		end

		// writes land on the edge that accepts them; busy erase wins
		if (avs_write && !state_reg.waitreq && prog_ok && !MASK_VARIANT
			&& state_reg.fsm == OBCD_IDLE) begin
			case (avs_address)
				OBCD_OFF_BYTE0: state_next.byte0 = avs_writedata[7:0];
				OBCD_OFF_BYTE1: state_next.byte1 = avs_writedata[7:0];
				OBCD_OFF_CTRL:
					if (avs_writedata[OBCD_CTRL_ERASE])
						state_next.fsm = state_reg.byte0[OBCD_B0_PROT]
							? OBCD_WIPE_OPT : OBCD_WIPE_USER;
				default: state_next.fsm = state_reg.fsm;
			endcase
		end

		if (reset || cold_reset) begin
			state_next.sync1 = '0;
			state_next.sync2 = '0;
			state_next.cap0 = '0;
			state_next.cap1 = '0;
			state_next.captured = 1'b0;
			state_next.hold_cnt = '0;
			state_next.reset_hold = 1'b1;
			state_next.halt_hold = 1'b0;
			state_next.fsm = OBCD_IDLE;
			state_next.user_erase = 1'b0;
			state_next.user_block = 1'b0;
			state_next.lvd_on = 1'b0;
			state_next.avd_on = 1'b0;
			state_next.pkg80 = 1'b0;
			state_next.pkg64 = 1'b0;
			state_next.src_res = 1'b0;
			state_next.src_rc = 1'b0;
			state_next.src_ext = 1'b0;
			state_next.range_hot = '0;
			state_next.range_drive = 1'b0;
			state_next.pad_pullup = '0;
			state_next.waitreq = 1'b1;
			state_next.rdata = '0;
		end
		// plain reset keeps the stored bytes; cold reset restores shipment
		if (cold_reset) begin
			state_next.byte0 = OBCD_SHIP_BYTE0;
			state_next.byte1 = OBCD_SHIP_BYTE1;
		end
	end

	always_ff @(posedge core_clk) begin
		state_reg <= state_next;
	end

	assign avs_readdata = state_reg.rdata;
	assign avs_waitrequest = state_reg.waitreq;
	assign halt_watchdog_reset_select = state_reg.cap0[OBCD_B0_HALT];
	assign watchdog_activation_select = state_reg.cap0[OBCD_B0_WDOG];
	assign clock_safety_disable = state_reg.cap0[OBCD_B0_SAFE];
	assign voltage_detect_level =
		state_reg.cap0[OBCD_B0_VD_HI:OBCD_B0_VD_LO];
	assign low_voltage_reset_detector = state_reg.lvd_on;
	assign aux_voltage_detector = state_reg.avd_on;
	assign package_80pin = state_reg.pkg80;
	assign package_64pin = state_reg.pkg64;
	assign readout_protect_n = state_reg.cap0[OBCD_B0_PROT];
	assign user_mem_block = state_reg.user_block;
	assign user_mem_erase = state_reg.user_erase;
	assign reset_delay_select = state_reg.cap1[OBCD_B1_DELAY];
	assign cpu_reset_hold = state_reg.reset_hold;
	assign halt_exit_hold = state_reg.halt_hold;
	assign clock_source_type = state_reg.cap1[OBCD_B1_SRC_HI:OBCD_B1_SRC_LO];
	assign clk_src_resonator = state_reg.src_res;
	assign clk_src_rc = state_reg.src_rc;
	assign clk_src_external = state_reg.src_ext;
	assign oscillator_range = state_reg.cap1[OBCD_B1_RNG_HI:OBCD_B1_RNG_LO];
	assign range_lowest = state_reg.range_hot[0];
	assign range_low_mid = state_reg.range_hot[1];
	assign range_high_mid = state_reg.range_hot[2];
	assign range_highest = state_reg.range_hot[3];
	assign range_sets_drive = state_reg.range_drive;
	assign doubler_disable = state_reg.cap1[OBCD_B1_DOUBLER];
	assign unbonded_pullup = state_reg.pad_pullup;

	// helper: length of the reset phase after capture
	logic [OBCD_CNT_W:0] hold_len;
	always_ff @(posedge core_clk) begin
		if (reset || cold_reset || !state_reg.captured)
			hold_len <= '0;
		else if (state_reg.reset_hold)
			hold_len <= hold_len + 1'b1;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset || cold_reset);

	hold_length_a: assert property ($fell(state_reg.reset_hold) |->
		hold_len == (state_reg.cap1[OBCD_B1_DELAY] ? (OBCD_CNT_W+1)'(SHORT_DELAY)
		: (OBCD_CNT_W+1)'(LONG_DELAY)))
		else $error("reset phase length wrong");
	frozen_cfg_a: assert property ($past(state_reg.captured)
		&& state_reg.captured |-> $stable({state_reg.cap0, state_reg.cap1}))
		else $error("captured settings changed");
	capture_src_a: assert property ($rose(state_reg.captured) |->
		clock_safety_disable == $past(src0[OBCD_B0_SAFE])
		&& doubler_disable == $past(src1[OBCD_B1_DOUBLER]))
		else $error("capture did not take stored bits");
	halt_wdog_a: assert property ($rose(state_reg.captured) |->
		halt_watchdog_reset_select == $past(src0[OBCD_B0_HALT])
		&& watchdog_activation_select == $past(src0[OBCD_B0_WDOG]))
		else $error("watchdog bits not captured");
	vd_decode_a: assert property (state_reg.captured |->
		low_voltage_reset_detector == (voltage_detect_level != OBCD_VD_OFF))
		else $error("voltage detector enable wrong");
	pkg_decode_a: assert property (state_reg.captured |->
		package_80pin == ({state_reg.cap1[OBCD_B1_PKG_HI],
		state_reg.cap0[OBCD_B0_PKG_LO]} == OBCD_PKG_80))
		else $error("package decode wrong");
	block_access_a: assert property (state_reg.captured
		&& !readout_protect_n && state_reg.sync2[OBCD_SY_TEST]
		|=> user_mem_block)
		else $error("protected memory not blocked");
	wipe_order_a: assert property (state_reg.fsm == OBCD_WIPE_OPT
		&& !$past(state_reg.byte0[OBCD_B0_PROT])
		|-> $past(state_reg.fsm) == OBCD_WIPE_USER)
		else $error("options erased before user memory");
	prog_only_a: assert property (avs_write && !avs_waitrequest
		&& !prog_ok |=> $stable({state_reg.byte0, state_reg.byte1}))
		else $error("option byte written outside programming mode");
	erased_ff_a: assert property (state_reg.fsm == OBCD_WIPE_OPT |=>
		state_reg.byte0 == OBCD_ERASED && state_reg.byte1 == OBCD_ERASED)
		else $error("erased bytes not all ones");
	src_decode_a: assert property (state_reg.captured |->
		clk_src_rc == (clock_source_type == OBCD_SRC_RC)
		&& range_sets_drive == (clock_source_type == OBCD_SRC_RESONATOR))
		else $error("clock source decode wrong");
	range_decode_a: assert property (state_reg.captured
		&& oscillator_range == OBCD_RNG_2_4 |-> range_low_mid
		&& !range_lowest && !range_high_mid && !range_highest)
		else $error("range decode wrong");
	pad_pullup_a: assert property (state_reg.captured |->
		unbonded_pullup == (package_64pin ? UNBONDED_64 : 8'h00))
		else $error("unbonded pad pull-up wrong");
	mask_fixed_a: assert property (MASK_VARIANT
		&& $rose(state_reg.captured)
		|-> state_reg.cap0 == MASK_BYTE0 && state_reg.cap1 == MASK_BYTE1)
		else $error("mask variant took stored bytes");

	wipe_cover: cover property (state_reg.fsm == OBCD_WIPE_USER
		##[1:50] state_reg.fsm == OBCD_WIPE_OPT);
	short_cover: cover property ($fell(state_reg.reset_hold)
		&& reset_delay_select);
	halt_cover: cover property ($fell(state_reg.halt_hold));
	prog_write_cover: cover property (avs_write && !avs_waitrequest
		&& prog_ok);
endmodule
`default_nettype wire

//--- obcd_pkg.sv
// Purpose: constants, encodings and state type of the option byte decoder
// Assumes: one 100 MHz core clock, Avalon-MM register access
// Notes: field positions follow the two static option bytes
`default_nettype none
package obcd_pkg;
	localparam int OBCD_ADDR_W = 5;
	localparam int OBCD_DATA_W = 32;
	localparam int OBCD_CNT_W = 13;
	// register byte offsets
	localparam logic [4:0] OBCD_OFF_BYTE0 = 5'h00;
	localparam logic [4:0] OBCD_OFF_BYTE1 = 5'h04;
	localparam logic [4:0] OBCD_OFF_CTRL = 5'h08;
	localparam logic [4:0] OBCD_OFF_STATUS = 5'h0c;
	localparam logic [4:0] OBCD_OFF_CAPTURED = 5'h10;
	// option byte 0 fields
	localparam int OBCD_B0_HALT = 7;
	localparam int OBCD_B0_WDOG = 6;
	localparam int OBCD_B0_SAFE = 5;
	localparam int OBCD_B0_VD_HI = 4;
	localparam int OBCD_B0_VD_LO = 3;
	localparam int OBCD_B0_PKG_LO = 1;
	localparam int OBCD_B0_PROT = 0;
	// option byte 1 fields
	localparam int OBCD_B1_PKG_HI = 7;
	localparam int OBCD_B1_DELAY = 6;
	localparam int OBCD_B1_SRC_HI = 5;
	localparam int OBCD_B1_SRC_LO = 4;
	localparam int OBCD_B1_RNG_HI = 3;
	localparam int OBCD_B1_RNG_LO = 1;
	localparam int OBCD_B1_DOUBLER = 0;
	// encodings
	localparam logic [1:0] OBCD_VD_OFF = 2'h3;
	localparam logic [1:0] OBCD_VD_LOWEST = 2'h2;
	localparam logic [1:0] OBCD_VD_MEDIUM = 2'h1;
	localparam logic [1:0] OBCD_VD_HIGHEST = 2'h0;
	localparam logic [1:0] OBCD_SRC_RESONATOR = 2'h0;
	localparam logic [1:0] OBCD_SRC_RESERVED = 2'h1;
	localparam logic [1:0] OBCD_SRC_RC = 2'h2;
	localparam logic [1:0] OBCD_SRC_EXTERNAL = 2'h3;
	localparam logic [2:0] OBCD_RNG_1_2 = 3'h0;
	localparam logic [2:0] OBCD_RNG_2_4 = 3'h1;
	localparam logic [2:0] OBCD_RNG_4_8 = 3'h2;
	localparam logic [2:0] OBCD_RNG_8_16 = 3'h3;
	localparam logic [1:0] OBCD_PKG_80 = 2'h3;
	localparam logic [1:0] OBCD_PKG_64 = 2'h2;
	// contents
	localparam logic [7:0] OBCD_ERASED = 8'hff;
	localparam logic [7:0] OBCD_SHIP_BYTE0 = 8'he7;
	localparam logic [7:0] OBCD_SHIP_BYTE1 = 8'hef;
	// reset phase lengths in core clock cycles
	localparam int OBCD_LONG_DELAY = 4096;
	localparam int OBCD_SHORT_DELAY = 256;
	// control and status bits
	localparam int OBCD_CTRL_ERASE = 0;
	localparam int OBCD_STAT_PROG = 0;
	localparam int OBCD_STAT_BUSY = 1;
	localparam int OBCD_STAT_HOLD = 2;
	localparam int OBCD_STAT_BLOCK = 3;
	localparam int OBCD_STAT_WIPE = 4;
	// synchroniser lanes
	localparam int OBCD_SY_PROG = 0;
	localparam int OBCD_SY_INCIRC = 1;
	localparam int OBCD_SY_TEST = 2;
	localparam int OBCD_SY_W = 3;

	typedef enum logic [2:0] {
		OBCD_IDLE = 3'b001,
		OBCD_WIPE_USER = 3'b010,
		OBCD_WIPE_OPT = 3'b100
	} obcd_fsm_e;

	typedef struct packed {
		logic [OBCD_SY_W-1:0] sync1;
		logic [OBCD_SY_W-1:0] sync2;
		logic [7:0] byte0;
		logic [7:0] byte1;
		logic [7:0] cap0;
		logic [7:0] cap1;
		logic captured;
		logic [OBCD_CNT_W-1:0] hold_cnt;
		logic reset_hold;
		logic halt_hold;
		obcd_fsm_e fsm;
		logic user_erase;
		logic user_block;
		logic lvd_on;
		logic avd_on;
		logic pkg80;
		logic pkg64;
		logic src_res;
		logic src_rc;
		logic src_ext;
		logic [3:0] range_hot;
		logic range_drive;
		logic [7:0] pad_pullup;
		logic waitreq;
		logic [OBCD_DATA_W-1:0] rdata;
	} obcd_state_s;
endpackage
`default_nettype wire

//--- obcd_prog_model.sv
// Purpose: programming tool model that loads the two option bytes
// Assumes: Avalon-MM master, every change right after a rising edge
// Notes: released write data shows the inverse so stale data never matches
`default_nettype none
module obcd_prog_model
	import obcd_pkg::*;
(
	input wire logic core_clk,
	input wire logic avs_waitrequest,
	output var logic [OBCD_ADDR_W-1:0] avs_address,
	output var logic avs_read,
	output var logic avs_write,
	output var logic [OBCD_DATA_W-1:0] avs_writedata,
	output var logic programming_mode
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		programming_mode = 1'b0;
	end

	task automatic set_mode(input logic m);
		@(posedge core_clk);
		programming_mode <= m;
	endtask

	// waitrequest is sampled on each rising edge; the request is released
	// at the very edge where it is seen low, or after 100 edges if it never is
	task automatic access(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output bit ok);
		ok = 1'b0;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (int i = 0; i < 100 && !ok; i++) begin
			@(posedge core_clk);
			ok = (avs_waitrequest === 1'b0);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
	endtask

	// b is {byte1, byte0}; the tool only ever offers supported combinations
	function automatic logic [15:0] legal(input logic [15:0] b);
		logic [15:0] r;
		r = b;
		r[2] = 1'b1;
		if (!r[0]) r[4:3] = 2'h3;
		if (r[13:12] == 2'h0) r[14] = 1'b0;
		if (r[13:12] != 2'h0 || r[11:9] != 3'h1) r[8] = 1'b1;
		return r;
	endfunction
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: self-checking bench for the option byte decoder
// Assumes: 100 MHz core_clk, shortened reset phase lengths
// Notes: expected read data is queued by the driver and checked by a monitor
`default_nettype none
module testbench;
	import obcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LONG_N = 16;
	localparam int SHORT_N = 4;
	localparam logic [7:0] PULL64 = 8'hf0;
	logic core_clk, reset, cold_reset, in_circuit_programming, test_mode;
	logic halt_exit, user_erase_done, programming_mode;
	logic [4:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata;
	logic halt_watchdog_reset_select, watchdog_activation_select;
	logic clock_safety_disable, low_voltage_reset_detector;
	logic aux_voltage_detector, package_80pin, package_64pin;
	logic readout_protect_n, user_mem_block, user_mem_erase;
	logic reset_delay_select, cpu_reset_hold, halt_exit_hold;
	logic clk_src_resonator, clk_src_rc, clk_src_external;
	logic range_lowest, range_low_mid, range_high_mid, range_highest;
	logic range_sets_drive, doubler_disable;
	logic [1:0] voltage_detect_level, clock_source_type;
	logic [2:0] oscillator_range;
	logic [7:0] unbonded_pullup;
	logic [31:0] expq[$];
	int n_mismatch = 0;
	int compares = 0;
	logic [15:0] cur, nb;
	logic [31:0] rv;
	wire logic [1:0] o_wdog = {halt_watchdog_reset_select,
		watchdog_activation_select};
	wire logic [3:0] o_vd = {voltage_detect_level, low_voltage_reset_detector,
		aux_voltage_detector};
	wire logic [9:0] o_pkg = {package_80pin, package_64pin, unbonded_pullup};
	wire logic [4:0] o_src = {clock_source_type, clk_src_resonator, clk_src_rc,
		clk_src_external};
	wire logic [7:0] o_rng = {oscillator_range, range_highest, range_high_mid,
		range_low_mid, range_lowest, range_sets_drive};

	obcd_option_decode #(.LONG_DELAY(LONG_N), .SHORT_DELAY(SHORT_N),
		.UNBONDED_64(PULL64)) u_obcd_option_decode (
		.core_clk, .reset, .cold_reset, .programming_mode,
		.in_circuit_programming, .test_mode, .halt_exit, .user_erase_done,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .halt_watchdog_reset_select,
		.watchdog_activation_select, .clock_safety_disable,
		.voltage_detect_level, .low_voltage_reset_detector,
		.aux_voltage_detector, .package_80pin, .package_64pin,
		.readout_protect_n, .user_mem_block, .user_mem_erase,
		.reset_delay_select, .cpu_reset_hold, .halt_exit_hold,
		.clock_source_type, .clk_src_resonator, .clk_src_rc,
		.clk_src_external, .oscillator_range, .range_lowest, .range_low_mid,
		.range_high_mid, .range_highest, .range_sets_drive, .doubler_disable,
		.unbonded_pullup
	);

	obcd_prog_model u_obcd_prog_model (
		.core_clk, .avs_waitrequest, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .programming_mode
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// read data is taken at the edge where waitrequest is sampled low
	always @(posedge core_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expq.size() > 0) begin
			check("readdata", avs_readdata, expq.pop_front());
		end
	end

	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		bit ok;
		u_obcd_prog_model.access(wr, a, {24'h0, d}, ok);
		if (!ok) begin
			n_mismatch++;
			end_sim();
		end
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	// entered right after an edge; hold is expected from the current cycle on
	task automatic count_hold(input bit halt, input int n);
		int cnt;
		cnt = 0;
		repeat (60) begin
			#1;
			if ((halt ? halt_exit_hold : cpu_reset_hold) === 1'b1) cnt++;
			@(posedge core_clk);
		end
		check(halt ? "halt_hold" : "reset_hold", cnt, n);
	endtask

	task automatic do_reset(input logic cold, input int n);
		@(posedge core_clk);
		reset <= 1'b1;
		cold_reset <= cold;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		cold_reset <= 1'b0;
		@(posedge core_clk);
		count_hold(1'b0, n);
	endtask

	task automatic do_halt(input int n);
		@(posedge core_clk);
		halt_exit <= 1'b1;
		@(posedge core_clk);
		halt_exit <= 1'b0;
		count_hold(1'b1, n);
	endtask

	task automatic chk_dec(input logic [15:0] b);
		logic [1:0] pk;
		logic [1:0] src;
		logic [2:0] rg;
		logic [7:0] pu;
		logic [3:0] hot;
		pk = {b[15], b[1]};
		src = b[13:12];
		rg = b[11:9];
		pu = (pk == 2'h2) ? PULL64 : 8'h00;
		hot = (rg < 3'h4) ? (4'h1 << rg) : 4'h0;
		check("wdog", o_wdog, b[7:6]);
		check("safety", clock_safety_disable, b[5]);
		check("vdet", o_vd, {b[4:3], {2{b[4:3] != 2'h3}}});
		check("pkg", o_pkg, {pk == 2'h3, pk == 2'h2, pu});
		check("protect", readout_protect_n, b[0]);
		check("delay", reset_delay_select, b[14]);
		check("src", o_src, {src, src == 2'h0, src == 2'h2, src == 2'h3});
		check("range", o_rng, {rg, hot, src == 2'h0});
		check("doubler", doubler_disable, b[8]);
	endtask

	initial begin
		reset = 1'b1;
		cold_reset = 1'b1;
		in_circuit_programming = 1'b0;
		test_mode = 1'b0;
		halt_exit = 1'b0;
		user_erase_done = 1'b0;
		rv = $urandom(53);
		do_reset(1'b1, SHORT_N);
		cur = 16'hefe7;
		chk_dec(cur);
		check("rc_default", clk_src_rc, 1'b1);
		rd(OBCD_OFF_BYTE0, 32'h0);
		wr(OBCD_OFF_BYTE0, 8'h00);
		u_obcd_prog_model.set_mode(1'b1);
		repeat (4) @(posedge core_clk);
		rd(OBCD_OFF_BYTE0, 32'he7);
		rd(5'h1c, 32'h0);
		for (int i = 0; i < 16; i++) begin
			rv = $urandom;
			nb[15:8] = {rv[15:14], i[2:1], rv[11], i[1:0], rv[8]};
			nb[7:0] = {rv[7:5], i[1:0], rv[2:1], i[3]};
			nb = u_obcd_prog_model.legal(nb);
			wr(OBCD_OFF_BYTE0, nb[7:0]);
			wr(OBCD_OFF_BYTE1, nb[15:8]);
			rd(OBCD_OFF_BYTE0, {24'h0, nb[7:0]});
			rd(OBCD_OFF_BYTE1, {24'h0, nb[15:8]});
			chk_dec(cur);
			do_reset(1'b0, nb[14] ? SHORT_N : LONG_N);
			cur = nb;
			chk_dec(cur);
			rd(OBCD_OFF_CAPTURED, {16'h0, nb});
			do_halt(nb[14] ? SHORT_N : LONG_N);
			in_circuit_programming <= rv[16];
			test_mode <= rv[17];
			repeat (4) @(posedge core_clk);
			#1;
			check("block", user_mem_block, !nb[0] && (rv[16] || rv[17]));
			rd(OBCD_OFF_STATUS, {28'h0, !nb[0] && (rv[16] || rv[17]),
				3'h1});
		end
		wr(OBCD_OFF_BYTE0, 8'hff);
		wr(OBCD_OFF_CTRL, 8'h01);
		repeat (2) @(posedge core_clk);
		rd(OBCD_OFF_BYTE0, 32'hff);
		rd(OBCD_OFF_BYTE1, 32'hff);
		// protected contents: user memory must be wiped before the bytes
		wr(OBCD_OFF_BYTE0, 8'hfe);
		wr(OBCD_OFF_BYTE1, 8'h00);
		wr(OBCD_OFF_CTRL, 8'h01);
		for (int k = 0; k < 50 && user_mem_erase !== 1'b1; k++) @(negedge core_clk);
		check("wipe_on", user_mem_erase, 1'b1);
		@(posedge core_clk);
		user_erase_done <= 1'b1;
		@(posedge core_clk);
		user_erase_done <= 1'b0;
		for (int k = 0; k < 50 && user_mem_erase !== 1'b0; k++) @(negedge core_clk);
		check("wipe_off", user_mem_erase, 1'b0);
		repeat (3) @(posedge core_clk);
		rd(OBCD_OFF_BYTE0, 32'hff);
		rd(OBCD_OFF_BYTE1, 32'hff);
		repeat (2) @(posedge core_clk);
		check("reads_left", expq.size(), 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
